// File: include/rrsf_pkg.sv
// constants shared by the ray speckle filter, its upstream model and its testbench
// assumes: bins arrive ray by ray, each bin carrying all parameters side by side
package rrsf_pkg;

	// parameter slots inside one bin
	localparam int NPAR = 5;
	localparam int P_UNC = 0; // uncorrected_reflectivity, total power
	localparam int P_COR = 1; // clutter_corrected_reflectivity
	localparam int P_DIFF = 2; // differential_reflectivity
	localparam int P_VEL = 3;
	localparam int P_WID = 4;

	// register map, word index on the plain register port
	localparam int AW = 4;
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_NYQ_HI = 4'h1;
	localparam logic [3:0] ADDR_NYQ_LO = 4'h2;
	localparam logic [3:0] ADDR_STATUS = 4'h3;
	localparam logic [3:0] ADDR_RAYS = 4'h4;
	localparam int RDW = 16;

	// control fields
	localparam int CTRL_REFL_1D = 0;
	localparam int CTRL_DOP_1D = 1;
	localparam int CTRL_OPT_LSB = 2;
	localparam int CTRL_USER_2D = 4;
	localparam int CTRL_UNFOLD = 5;
	localparam logic [7:0] CTRL_RESET = 8'h03;
	localparam logic [15:0] NYQ_RESET = 16'h0100;

	// 3x3 decision thresholds
	localparam logic [3:0] ISOL_MAX_NB = 4'h1;
	localparam logic [3:0] FILL_MIN_NB = 4'h6;
	// window slots: row*3+col, rows old/mid/new, cols bin-1/bin/bin+1
	localparam int W_CTR = 4;
	localparam logic [31:0] NEAR_ORD = 32'h86207153;

	typedef enum logic [1:0] {
		OPT_OFF = 2'h0,
		OPT_USER = 2'h1,
		OPT_ALWAYS = 2'h2
	} rrsf_opt_t;

	typedef enum logic [0:0] {
		S_FILL = 1'h0,
		S_PASS = 1'h1
	} rrsf_state_t;

endpackage

// File: src/rrsf_filter.sv
// ray speckle filter: input buffer and the final-pass filter
// assumes: upstream qualifier logic on the same clock, downstream always accepts output bins
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// input buffer
// ****************************************
module rrsf_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// fill side
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [W-1:0] i_data,
	// drain side
	output logic o_valid,
	input wire logic i_ready,
	output logic [W-1:0] o_data,
	output logic [$clog2(DEPTH):0] o_level
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] next_level;
	logic push;
	logic pop;

	initial begin
		if (DEPTH < 2 || (1 << PW) != DEPTH) $error("fifo depth must be a power of two");
	end

	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;
	assign o_valid = (o_level != '0);
	assign o_data = mem[rd_ptr];
	assign next_level = o_level + (PW+1)'(push) - (PW+1)'(pop);

	always_ff @(posedge i_core_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_data;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			o_level <= '0;
			o_ready <= 1'b0;
		end else begin
			wr_ptr <= wr_ptr + PW'(push);
			rd_ptr <= rd_ptr + PW'(pop);
			o_level <= next_level;
			o_ready <= (next_level != (PW+1)'(DEPTH));
		end
	end
endmodule

// ****************************************
// speckle filter top
// ****************************************
module rrsf_filter #(
	parameter int DW = 16,
	parameter int MAXB = 2048,
	parameter int FDEPTH = 16
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// register port
	input wire logic [rrsf_pkg::AW-1:0] i_addr,
	input wire logic [rrsf_pkg::RDW-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [rrsf_pkg::RDW-1:0] o_rdata,
	// bins from the qualifier stage
	input wire logic i_bin_valid,
	output logic o_bin_ready,
	input wire logic [rrsf_pkg::NPAR*DW-1:0] i_bin_data,
	input wire logic [rrsf_pkg::NPAR-1:0] i_bin_ok,
	input wire logic i_bin_last,
	input wire logic i_ray_high_prf,
	// filtered bins to the output stage
	output logic o_out_valid,
	output logic [rrsf_pkg::NPAR*DW-1:0] o_out_data,
	output logic [rrsf_pkg::NPAR-1:0] o_out_ok,
	output logic o_out_last
);
	localparam int NP = rrsf_pkg::NPAR;
	localparam int BW = $clog2(MAXB+1);
	localparam int FW = NP*DW + NP + 2;
	localparam int FLW = $clog2(FDEPTH) + 1;

	initial begin
		if (DW < 4 || DW > rrsf_pkg::RDW) $error("bin width out of range");
		if (MAXB < 2) $error("ray length too small");
		// the store is indexed by the low bits of the bin count
		if ((1 << $clog2(MAXB)) != MAXB) $error("ray length must be a power of two");
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	// ****************************************
	// registers
	// ****************************************
	logic [7:0] ctrl;
	logic [DW-1:0] nyq_hi;
	logic [DW-1:0] nyq_lo;
	logic [15:0] ray_cnt;
	rrsf_pkg::rrsf_state_t state;
	logic [1:0] rays_seen;
	logic [FLW-1:0] f_level;
	logic en2d;
	logic [1:0] opt;

	assign opt = ctrl[rrsf_pkg::CTRL_OPT_LSB +: 2];
	assign en2d = (opt == rrsf_pkg::OPT_ALWAYS) ||
		(opt == rrsf_pkg::OPT_USER && ctrl[rrsf_pkg::CTRL_USER_2D]);

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl <= rrsf_pkg::CTRL_RESET;
			nyq_hi <= DW'(rrsf_pkg::NYQ_RESET);
			nyq_lo <= DW'(rrsf_pkg::NYQ_RESET);
		end else if (i_wr) begin
			case (i_addr)
				rrsf_pkg::ADDR_CTRL: ctrl <= i_wdata[7:0];
				rrsf_pkg::ADDR_NYQ_HI: nyq_hi <= i_wdata[DW-1:0];
				rrsf_pkg::ADDR_NYQ_LO: nyq_lo <= i_wdata[DW-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= '0;
		end else if (i_rd) begin
			case (i_addr)
				rrsf_pkg::ADDR_CTRL: o_rdata <= {8'h00, ctrl};
				rrsf_pkg::ADDR_NYQ_HI: o_rdata <= 16'(nyq_hi);
				rrsf_pkg::ADDR_NYQ_LO: o_rdata <= 16'(nyq_lo);
				rrsf_pkg::ADDR_STATUS: o_rdata <= 16'({f_level, rays_seen, en2d, state});
				rrsf_pkg::ADDR_RAYS: o_rdata <= ray_cnt;
				default: o_rdata <= '0;
			endcase
		end else begin
			o_rdata <= '0;
		end
	end

	// ****************************************
	// input buffer and ray store
	// ****************************************
	logic f_valid;
	logic f_take;
	logic [FW-1:0] f_word;
	logic [NP*DW-1:0] f_data;
	logic [NP-1:0] f_ok;
	logic f_last;
	logic f_hi;

	// bin value and validity travel together through the buffer
	rrsf_fifo #(.W(FW), .DEPTH(FDEPTH)) u_fifo (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_valid(i_bin_valid),
		.o_ready(o_bin_ready),
		.i_data({i_ray_high_prf, i_bin_last, i_bin_ok, i_bin_data}),
		.o_valid(f_valid),
		.i_ready(f_take),
		.o_data(f_word),
		.o_level(f_level)
	);
	assign {f_hi, f_last, f_ok, f_data} = f_word;
	// draining stops for the whole pass, so the 3x3 costs ray-length cycles per ray
	assign f_take = f_valid && (state == rrsf_pkg::S_FILL);

	logic [DW-1:0] mem [3][NP][MAXB];
	logic okm [3][NP][MAXB];
	logic [BW-1:0] len [3];
	logic [1:0] cur;
	logic [BW-1:0] wbin;
	logic [BW-1:0] pbin;

	function automatic logic [1:0] prev3(input logic [1:0] b);
		return (b == 2'h0) ? 2'h2 : b - 2'h1;
	endfunction

	// reads as not valid beyond the ray ends or when the ray is absent
	function automatic logic in_ray(input logic [1:0] bk, input logic present, input int idx);
		return present && idx >= 0 && idx < int'(len[bk]);
	endfunction

	// ****************************************
	// dual-prf unfolding on the arriving ray
	// ****************************************
	logic [1:0] pb;
	logic signed [DW+1:0] vin;
	logic signed [DW+1:0] nq2;
	logic signed [DW+1:0] partner;
	logic signed [DW+1:0] cand;
	logic found;
	logic [DW-1:0] vel_w;
	int sidx;

	function automatic logic [DW+1:0] absd(input logic signed [DW+1:0] a);
		return a[DW+1] ? -a : a;
	endfunction

	always_comb begin
		pb = prev3(cur);
		vin = (DW+2)'($signed(f_data[rrsf_pkg::P_VEL*DW +: DW]));
		nq2 = (DW+2)'({f_hi ? nyq_hi : nyq_lo, 1'b0});
		partner = '0;
		found = 1'b0;
		// nearest first: same bin, then the earlier and later range bins
		for (int k = 2; k >= 0; k--) begin
			sidx = int'(wbin) + ((k == 0) ? 0 : ((k == 1) ? -1 : 1));
			if (in_ray(pb, rays_seen != 2'h0, sidx) &&
				okm[pb][rrsf_pkg::P_VEL][sidx[BW-2:0]]) begin
				found = 1'b1;
				partner = (DW+2)'($signed(mem[pb][rrsf_pkg::P_VEL][sidx[BW-2:0]]));
			end
		end
		cand = vin;
		if (absd(vin + nq2 - partner) < absd(cand - partner)) cand = vin + nq2;
		if (absd(vin - nq2 - partner) < absd(cand - partner)) cand = vin - nq2;
		vel_w = f_data[rrsf_pkg::P_VEL*DW +: DW];
		if (en2d && ctrl[rrsf_pkg::CTRL_UNFOLD] && found && f_ok[rrsf_pkg::P_VEL]) begin
			vel_w = cand[DW-1:0];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (f_take && wbin < BW'(MAXB)) begin
			for (int p = 0; p < NP; p++) begin
				mem[cur][p][wbin[BW-2:0]] <= (p == rrsf_pkg::P_VEL) ? vel_w : f_data[p*DW +: DW];
				okm[cur][p][wbin[BW-2:0]] <= f_ok[p];
			end
		end
	end

	// ****************************************
	// ray sequencing
	// ****************************************
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= rrsf_pkg::S_FILL;
			cur <= 2'h0;
			wbin <= '0;
			pbin <= '0;
			rays_seen <= 2'h0;
			ray_cnt <= '0;
			len[0] <= '0;
			len[1] <= '0;
			len[2] <= '0;
		end else begin
			case (state)
				rrsf_pkg::S_FILL: begin
					if (f_take) begin
						// bins past the store size are dropped
						if (wbin < BW'(MAXB)) wbin <= wbin + BW'(1);
						if (f_last) begin
							len[cur] <= (wbin < BW'(MAXB)) ? wbin + BW'(1) : wbin;
							wbin <= '0;
							pbin <= '0;
							if (rays_seen != 2'h0) begin
								state <= rrsf_pkg::S_PASS;
							end else begin
								rays_seen <= 2'h1;
								cur <= (cur == 2'h2) ? 2'h0 : cur + 2'h1;
							end
						end
					end
				end
				rrsf_pkg::S_PASS: begin
					pbin <= pbin + BW'(1);
					if (pbin + BW'(1) >= len[prev3(cur)]) begin
						state <= rrsf_pkg::S_FILL;
						rays_seen <= 2'h2;
						ray_cnt <= ray_cnt + 16'h0001;
						cur <= (cur == 2'h2) ? 2'h0 : cur + 2'h1;
					end
				end
				default: state <= rrsf_pkg::S_FILL;
			endcase
		end
	end

	// ****************************************
	// per-parameter window and decision
	// ****************************************
	wire logic [NP*DW-1:0] next_data;
	wire logic [NP-1:0] next_ok;

	for (genvar p = 0; p < NP; p++) begin : g_par
		logic [8:0] ok;
		logic [DW-1:0] v [9];
		logic [3:0] cnt;
		logic [DW+2:0] sum;
		logic [DW-1:0] near;
		logic [DW-1:0] nval;
		logic nok;
		logic en1d;
		logic [1:0] bk;
		int idx;

		assign en1d = (p <= rrsf_pkg::P_DIFF) ? ctrl[rrsf_pkg::CTRL_REFL_1D]
			: ctrl[rrsf_pkg::CTRL_DOP_1D];

		always_comb begin
			cnt = '0;
			sum = '0;
			near = '0;
			bk = 2'h0;
			idx = 0;
			for (int r = 0; r < 3; r++) begin
				for (int c = 0; c < 3; c++) begin
					bk = (r == 2) ? cur : ((r == 1) ? prev3(cur) : prev3(prev3(cur)));
					idx = int'(pbin) + c - 1;
					ok[r*3+c] = in_ray(bk, (r != 0) || (rays_seen == 2'h2), idx) &&
						okm[bk][p][idx[BW-2:0]];
					v[r*3+c] = mem[bk][p][idx[BW-2:0]];
				end
			end
			for (int k = 0; k < 9; k++) begin
				if (k != rrsf_pkg::W_CTR && ok[k]) begin
					cnt = cnt + 4'h1;
					sum = sum + (DW+3)'(v[k]);
				end
			end
			for (int k = 7; k >= 0; k--) begin
				if (ok[rrsf_pkg::NEAR_ORD[k*4 +: 4]]) near = v[rrsf_pkg::NEAR_ORD[k*4 +: 4]];
			end
			nval = v[rrsf_pkg::W_CTR];
			nok = ok[rrsf_pkg::W_CTR];
			if (en2d && p != rrsf_pkg::P_DIFF) begin
				if (ok[rrsf_pkg::W_CTR]) begin
					nok = (cnt > rrsf_pkg::ISOL_MAX_NB);
				end else if (cnt >= rrsf_pkg::FILL_MIN_NB) begin
					nok = 1'b1;
					nval = (p == rrsf_pkg::P_VEL) ? near
						: DW'(sum / (DW+3)'(cnt));
				end
			end else if (en1d) begin
				nok = ok[rrsf_pkg::W_CTR] && (ok[3] || ok[5]);
			end
		end

		assign next_data[p*DW +: DW] = nval;
		assign next_ok[p] = nok;
	end

	// ****************************************
	// output stage
	// ****************************************
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_out_valid <= 1'b0;
			o_out_data <= '0;
			o_out_ok <= '0;
			o_out_last <= 1'b0;
		end else begin
			o_out_valid <= (state == rrsf_pkg::S_PASS);
			o_out_data <= next_data;
			o_out_ok <= (state == rrsf_pkg::S_PASS) ? next_ok : '0;
			o_out_last <= (state == rrsf_pkg::S_PASS) && (pbin + BW'(1) >= len[prev3(cur)]);
		end
	end

	// ****************************************
	// checks
	// ****************************************
	property p_iso_1d;
		state == rrsf_pkg::S_PASS && !en2d && ctrl[rrsf_pkg::CTRL_DOP_1D] &&
			g_par[rrsf_pkg::P_WID].ok[4] && !g_par[rrsf_pkg::P_WID].ok[3] &&
			!g_par[rrsf_pkg::P_WID].ok[5] |=> o_out_valid && !o_out_ok[rrsf_pkg::P_WID];
	endproperty
	a_iso_1d: assert property (p_iso_1d) else $error("isolated bin not removed");

	property p_diff_off;
		state == rrsf_pkg::S_PASS && !ctrl[rrsf_pkg::CTRL_REFL_1D] |=>
			o_out_ok[rrsf_pkg::P_DIFF] == $past(g_par[rrsf_pkg::P_DIFF].ok[4]) &&
			o_out_data[rrsf_pkg::P_DIFF*DW +: DW] == $past(g_par[rrsf_pkg::P_DIFF].v[4]);
	endproperty
	a_diff_off: assert property (p_diff_off) else $error("disabled remover altered bin");

	property p_diff_no2d;
		state == rrsf_pkg::S_PASS && en2d && ctrl[rrsf_pkg::CTRL_REFL_1D] &&
			g_par[rrsf_pkg::P_DIFF].ok[4] && g_par[rrsf_pkg::P_DIFF].ok[3] |=>
			o_out_ok[rrsf_pkg::P_DIFF];
	endproperty
	a_diff_no2d: assert property (p_diff_no2d) else $error("3x3 applied to differential");

	property p_2d_iso;
		state == rrsf_pkg::S_PASS && en2d && g_par[rrsf_pkg::P_COR].ok[4] &&
			g_par[rrsf_pkg::P_COR].cnt <= 4'h1 |=> !o_out_ok[rrsf_pkg::P_COR];
	endproperty
	a_2d_iso: assert property (p_2d_iso) else $error("isolated centre kept");

	property p_2d_keep;
		state == rrsf_pkg::S_PASS && en2d && g_par[rrsf_pkg::P_UNC].ok[4] &&
			g_par[rrsf_pkg::P_UNC].cnt >= 4'h2 |=> o_out_ok[rrsf_pkg::P_UNC] &&
			o_out_data[rrsf_pkg::P_UNC*DW +: DW] == $past(g_par[rrsf_pkg::P_UNC].v[4]);
	endproperty
	a_2d_keep: assert property (p_2d_keep) else $error("valid centre changed");

	property p_fill_gate;
		state == rrsf_pkg::S_PASS && en2d && !g_par[rrsf_pkg::P_WID].ok[4] |=>
			o_out_ok[rrsf_pkg::P_WID] == ($past(g_par[rrsf_pkg::P_WID].cnt) >= 4'h6);
	endproperty
	a_fill_gate: assert property (p_fill_gate) else $error("fill count threshold wrong");

	property p_vel_near;
		state == rrsf_pkg::S_PASS && en2d && !g_par[rrsf_pkg::P_VEL].ok[4] &&
			g_par[rrsf_pkg::P_VEL].cnt >= 4'h6 && g_par[rrsf_pkg::P_VEL].ok[3] |=>
			o_out_data[rrsf_pkg::P_VEL*DW +: DW] == $past(g_par[rrsf_pkg::P_VEL].v[3]);
	endproperty
	a_vel_near: assert property (p_vel_near) else $error("velocity fill not nearest");

	property p_pass_stall;
		state == rrsf_pkg::S_PASS |-> !f_take ##1 o_out_valid;
	endproperty
	a_pass_stall: assert property (p_pass_stall) else $error("buffer drained during pass");

	property p_first_ray;
		f_take && f_last && rays_seen == 2'h0 |=> state == rrsf_pkg::S_FILL ##1 !o_out_valid;
	endproperty
	a_first_ray: assert property (p_first_ray) else $error("output before second ray");

	c_fill: cover property (o_out_valid && state == rrsf_pkg::S_PASS && en2d &&
		!g_par[rrsf_pkg::P_COR].ok[4] && g_par[rrsf_pkg::P_COR].cnt >= 4'h6);
	c_unfold: cover property (f_take && vel_w != f_data[rrsf_pkg::P_VEL*DW +: DW]);
	c_full: cover property (!o_bin_ready);
	c_last: cover property (o_out_last);
endmodule

`default_nettype wire

// File: bench/rrsf_upstream.sv
// upstream model: moment and qualifier stage handing bins to the speckle filter
// assumes: valid/ready handshake sampled on the rising edge of i_core_clk
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// upstream bin source
// ****************************************
module rrsf_upstream #(
	parameter int DW = 16
) (
	// clock
	input wire logic i_core_clk,
	// bins to the filter
	output logic o_bin_valid,
	input wire logic i_bin_ready,
	output logic [rrsf_pkg::NPAR*DW-1:0] o_bin_data,
	output logic [rrsf_pkg::NPAR-1:0] o_bin_ok,
	output logic o_bin_last,
	output logic o_ray_high_prf
);
	initial begin
		o_bin_valid = 1'b0;
		o_bin_data = '0;
		o_bin_ok = '0;
		o_bin_last = 1'b0;
		o_ray_high_prf = 1'b0;
	end

	// enter just after a rising edge; leaves just after the edge that took the last bin
	task automatic send_ray(input int r, input int len, input logic [31:0] mask);
		logic [DW-1:0] v;
		for (int b = 0; b < len; b++) begin
			v = DW'(r * 32 + b + 1);
			o_bin_valid <= 1'b1;
			o_bin_data <= {rrsf_pkg::NPAR{v}};
			o_bin_ok <= {rrsf_pkg::NPAR{mask[b]}};
			o_bin_last <= (b == len - 1);
			o_ray_high_prf <= r[0];
			// ready is registered, so its level at the fall holds at the next rise
			@(negedge i_core_clk);
			while (i_bin_ready !== 1'b1) @(negedge i_core_clk);
			@(posedge i_core_clk);
		end
		// released data and ok lines show the inverse of the last bin, never a stale copy
		o_bin_valid <= 1'b0;
		o_bin_data <= ~o_bin_data;
		o_bin_ok <= ~o_bin_ok;
		o_bin_last <= 1'b0;
	endtask
endmodule

`default_nettype wire

// File: bench/testbench.sv
// testbench for the ray speckle filter: registers, single-ray and 3x3 passes
// assumes: the upstream model drives bins, downstream accepts every output bin
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// bench top
// ****************************************
module testbench;
	localparam int DW = 16;
	localparam int L1 = 24;
	localparam int L2 = 6;
	logic i_core_clk, i_rst_n, i_wr, i_rd;
	logic [rrsf_pkg::AW-1:0] i_addr;
	logic [rrsf_pkg::RDW-1:0] i_wdata, o_rdata;
	logic bin_valid, bin_ready, bin_last, high_prf, o_out_valid, o_out_last;
	logic [rrsf_pkg::NPAR*DW-1:0] bin_data, o_out_data;
	logic [rrsf_pkg::NPAR-1:0] bin_ok, o_out_ok;
	logic [rrsf_pkg::NPAR*DW-1:0] q_data[$];
	logic [rrsf_pkg::NPAR-1:0] q_ok[$];
	logic q_last[$];
	logic saw_full;
	int errors, n_checks;
	logic [31:0] m1;
	// centre ray holds a gap at bin 1 and an isolated bin at the far end
	logic [31:0] m3a = 32'h0000000f;
	logic [31:0] m3b = 32'h0000002d;
	logic [7:0] c1[4] = '{8'h00, 8'h01, 8'h02, 8'h03};
	// 0x3c asks for unfolding with the 3x3 off, 0x2b with it on
	logic [7:0] c2[5] = '{8'h0b, 8'h14, 8'h04, 8'h3c, 8'h2b};
	logic on[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

	rrsf_filter #(.DW(DW), .MAXB(32), .FDEPTH(16)) uut (
		.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_bin_valid(bin_valid), .o_bin_ready(bin_ready), .i_bin_data(bin_data),
		.i_bin_ok(bin_ok), .i_bin_last(bin_last), .i_ray_high_prf(high_prf),
		.o_out_valid(o_out_valid), .o_out_data(o_out_data), .o_out_ok(o_out_ok),
		.o_out_last(o_out_last)
	);

	rrsf_upstream #(.DW(DW)) up (
		.i_core_clk(i_core_clk), .o_bin_valid(bin_valid), .i_bin_ready(bin_ready),
		.o_bin_data(bin_data), .o_bin_ok(bin_ok), .o_bin_last(bin_last),
		.o_ray_high_prf(high_prf)
	);

	initial begin
		i_core_clk = 1'b0;
		forever #50 i_core_clk = ~i_core_clk;
	end

	// outputs stand one cycle each, so collect them mid-cycle
	always @(negedge i_core_clk) begin
		if (o_out_valid === 1'b1) begin
			q_data.push_back(o_out_data);
			q_ok.push_back(o_out_ok);
			q_last.push_back(o_out_last);
		end
		if (i_rst_n === 1'b1 && bin_valid === 1'b1 && bin_ready === 1'b0) saw_full = 1'b1;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks=%0d mismatches=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_core_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge i_core_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		@(negedge i_core_clk);
		d = o_rdata;
	endtask

	task automatic reg_chk(input logic [3:0] a, input logic [15:0] exp);
		logic [15:0] d;
		reg_rd(a, d);
		chk(32'(d), 32'(exp));
	endtask

	task automatic do_reset();
		@(posedge i_core_clk);
		i_rst_n <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		q_data.delete();
		q_ok.delete();
		q_last.delete();
		saw_full = 1'b0;
	endtask

	task automatic send_rays(input int len, input logic [31:0] ma, input logic [31:0] mb);
		for (int r = 0; r < 3; r++) begin
			@(posedge i_core_clk);
			up.send_ray(r, len, (r == 1) ? mb : ma);
		end
	endtask

	task automatic wait_out(input int n);
		int k;
		k = 0;
		while (q_data.size() < n && k < 2000) begin
			@(negedge i_core_clk);
			k++;
		end
		chk(32'(q_data.size()), 32'(n));
	endtask

	function automatic logic exp1d(input logic [31:0] m, input int b, input int len,
		input logic en);
		return m[b] && !(en && (b == 0 || !m[b-1]) && (b == len - 1 || !m[b+1]));
	endfunction

	initial begin
		repeat (20000) @(posedge i_core_clk);
		errors++;
		close_out();
	end

	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		logic e, en;
		logic [15:0] v, d;
		i_rst_n = 1'b0;
		i_addr = '0;
		i_wdata = '0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		errors = 0;
		n_checks = 0;
		for (int b = 0; b < 32; b++) m1[b] = (b % 5 != 1) && (b % 5 != 3);
		do_reset();
		reg_chk(rrsf_pkg::ADDR_CTRL, 16'h0003);
		reg_chk(rrsf_pkg::ADDR_NYQ_HI, 16'h0100);
		reg_chk(rrsf_pkg::ADDR_NYQ_LO, 16'h0100);
		reg_wr(rrsf_pkg::ADDR_RAYS, 16'h1234);
		reg_chk(rrsf_pkg::ADDR_RAYS, 16'h0000);
		reg_wr(4'hf, 16'hffff);
		reg_chk(4'hf, 16'h0000);
		reg_wr(rrsf_pkg::ADDR_CTRL, 16'hff3f);
		reg_chk(rrsf_pkg::ADDR_CTRL, 16'h003f);
		reg_wr(rrsf_pkg::ADDR_NYQ_LO, 16'habcd);
		reg_chk(rrsf_pkg::ADDR_NYQ_LO, 16'habcd);
		$display("test registers done");
		foreach (c1[i]) begin
			do_reset();
			reg_wr(rrsf_pkg::ADDR_CTRL, 16'(c1[i]));
			send_rays(L1, m1, m1);
			wait_out(2 * L1);
			chk(32'(saw_full), 32'h1);
			for (int b = 0; b < L1; b++) begin
				for (int s = 0; s < rrsf_pkg::NPAR; s++) begin
					en = (s < rrsf_pkg::P_VEL) ? c1[i][rrsf_pkg::CTRL_REFL_1D] :
						c1[i][rrsf_pkg::CTRL_DOP_1D];
					e = exp1d(m1, b, L1, en);
					chk(32'(q_ok[b][s]), 32'(e));
					if (e) chk(32'(q_data[b][s*DW+:DW]), 32'(b + 1));
				end
				chk(32'(q_last[b]), 32'(b == L1 - 1));
			end
			reg_chk(rrsf_pkg::ADDR_RAYS, 16'h0002);
			$display("test single-ray ctrl=%h done", c1[i]);
		end
		foreach (c2[i]) begin
			do_reset();
			reg_wr(rrsf_pkg::ADDR_CTRL, 16'(c2[i]));
			reg_rd(rrsf_pkg::ADDR_STATUS, d);
			chk(32'(d[1]), 32'(on[i]));
			// a small high-rate limit makes the centre ray fold against ray 0
			if (c2[i][rrsf_pkg::CTRL_UNFOLD]) reg_wr(rrsf_pkg::ADDR_NYQ_HI, 16'h0008);
			send_rays(L2, m3a, m3b);
			wait_out(2 * L2);
			for (int b = 0; b < L2; b++) begin
				for (int s = 0; s < rrsf_pkg::NPAR; s++) begin
					v = 16'(33 + b);
					if (on[i] && s != rrsf_pkg::P_DIFF) begin
						e = m3a[b];
						// gap at bin 1 has eight valid neighbours around it
						if (b == 1) v = (s == rrsf_pkg::P_VEL) ? 16'h0021 : 16'h0022;
						// centre ray velocities sit closest to ray 0 after subtracting 2 x 8
						if (s == rrsf_pkg::P_VEL && c2[i][rrsf_pkg::CTRL_UNFOLD]) v = v - 16'h0010;
					end else begin
						en = (s < rrsf_pkg::P_VEL) ? c2[i][rrsf_pkg::CTRL_REFL_1D] :
							c2[i][rrsf_pkg::CTRL_DOP_1D];
						e = exp1d(m3b, b, L2, en);
					end
					chk(32'(q_ok[L2+b][s]), 32'(e));
					if (e) chk(32'(q_data[L2+b][s*DW+:DW]), 32'(v));
				end
			end
			$display("test window ctrl=%h done", c2[i]);
		end
		close_out();
	end
endmodule

`default_nettype wire
